// *** pkg/vds_pkg.sv ***
// vds_pkg: register numbers, field layouts, reset values and states shared by the
// vlan / priority table access block.
// assumes a management port that addresses registers by their register number.
package vds_pkg;
    // ---------------------------------------------------------------
    // register numbers
    // ---------------------------------------------------------------
    localparam logic [15:0] REG_VLAN_READ_VALUE      = 16'h180e;
    localparam logic [15:0] REG_VLAN_COMMAND_STATE   = 16'h1810;
    localparam logic [15:0] REG_PRIO_TABLE_COMMAND   = 16'h1811;
    localparam logic [15:0] REG_PRIO_TABLE_WRITE_VAL = 16'h1812;
    localparam logic [15:0] REG_PRIO_TABLE_READ_VAL  = 16'h1813;
    localparam logic [15:0] REG_PRIO_TABLE_CMD_STATE = 16'h1814;
    // ---------------------------------------------------------------
    // field layouts
    // ---------------------------------------------------------------
    localparam int          CMD_W         = 8;
    localparam int          CMD_READ_POS  = 7;
    localparam int          INDEX_W       = 6;
    localparam logic [7:0]  CMD_WMASK     = 8'hbf;
    localparam int          PRIO_W        = 3;
    localparam int          PEND_POS      = 0;
    localparam int          VL_ENTRY_W    = 18;
    localparam int          VID_W         = 12;
    localparam int          VL_UNTAG0_POS = 12;
    localparam int          VL_MEMBER0_POS = 13;
    localparam int          VL_STRIDE     = 2;
    localparam int          VL_PORTS      = 3;
    localparam int          VL_ENTRIES    = 16;
    localparam int          VL_INDEX_W    = 4;
    localparam logic [17:0] PVID_MASK     = 18'h07fff;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  CMD_RST       = 8'h00;
    localparam logic [2:0]  PRIO_RST      = 3'h0;
    localparam logic [17:0] VL_ENTRY_RST  = 18'h00000;

    typedef enum logic [1:0] {VDS_IDLE, VDS_ACCESS, VDS_DONE} vds_phase_e;
endpackage : vds_pkg

// *** pkg/vds_mem_if.sv ***
// vds_mem_if: command port and lookup port of the priority table memory.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface vds_mem_if #(
    parameter int AW = 6,
    parameter int DW = 3
);
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rq;
    logic [AW-1:0] lk_addr;
    logic [DW-1:0] lk_q;

    modport ctrl (output we, output addr, output wdata, output lk_addr,
                  input rq, input lk_q);
    modport mem  (input we, input addr, input wdata, input lk_addr,
                  output rq, output lk_q);
endinterface : vds_mem_if
`default_nettype wire

// *** src/vds_prio_mem.sv ***
// vds_prio_mem: priority table storage, one write/read port and one lookup port.
// assumes contents start undefined; no reset reaches the array.
`timescale 1ns/1ps
`default_nettype none
module vds_prio_mem #(
    parameter int AW = 6,
    parameter int DW = 3
) (
    input wire logic mclk,
    vds_mem_if.mem   bus
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // no reset on the array or its outputs
    always_ff @(posedge mclk) begin
        if (bus.we) begin
            mem_r[bus.addr] <= bus.wdata;
        end
        bus.rq   <= mem_r[bus.addr];
        bus.lk_q <= mem_r[bus.lk_addr];
    end
endmodule : vds_prio_mem
`default_nettype wire

// *** src/vds_vlan_match.sv ***
// vds_vlan_match: finds the vlan entry whose id equals the looked-up id.
// assumes entries of id zero are disabled; lowest index wins on duplicates.
`timescale 1ns/1ps
`default_nettype none
module vds_vlan_match #(
    parameter int ENTRIES = 16
) (
    input  wire logic [ENTRIES-1:0][17:0] table_in,
    input  wire logic [11:0]              vid,
    output logic                          hit,
    output logic [2:0]                    member,
    output logic [2:0]                    untag
);
    function automatic logic [2:0] pick(input logic [17:0] e, input int base);
        logic [2:0] r;
        r = '0;
        for (int p = 0; p < vds_pkg::VL_PORTS; p++) begin
            r[p] = e[base + p * vds_pkg::VL_STRIDE];
        end
        return r;
    endfunction : pick

    always_comb begin
        hit    = 1'b0;
        member = '0;
        untag  = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (vid != 12'h000 && table_in[i][vds_pkg::VID_W-1:0] == vid) begin
                hit    = 1'b1;
                member = pick(table_in[i], vds_pkg::VL_MEMBER0_POS);
                untag  = pick(table_in[i], vds_pkg::VL_UNTAG0_POS);
            end
        end
    end
endmodule : vds_vlan_match
`default_nettype wire

// *** src/vds_table_access.sv ***
// vds_table_access: indirect access to the vlan and priority tables plus the
// per-packet vlan and priority lookups that consume them.
// assumes a management port with one-cycle read/write strobes addressed by
// register number; vlan command fields arrive as plain ports.
`timescale 1ns/1ps
`default_nettype none
module vds_table_access #(
    parameter int VL_ENTRIES = 16,
    parameter int INDEX_W    = 6,
    parameter int PRIO_W     = 3
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    // management port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata_q,
    output logic             reg_rvalid_q,
    // vlan command fields
    input  wire logic        vlan_cmd_start,
    input  wire logic        vlan_cmd_read,
    input  wire logic        default_id_table_select,
    input  wire logic [3:0]  vlan_cmd_index,
    input  wire logic [17:0] vlan_write_value,
    output logic      [17:0] vlan_read_value_q,
    // per-packet vlan lookup
    input  wire logic        lookup_valid,
    input  wire logic [11:0] lookup_vid,
    input  wire logic [1:0]  lookup_port,
    input  wire logic [2:0]  admit_outsider_ports,
    input  wire logic [2:0]  egress_port_kind,
    output logic             lookup_valid_q,
    output logic             vlan_admit_q,
    output logic      [2:0]  vlan_egress_q,
    output logic      [2:0]  vlan_strip_q,
    // priority lookup
    input  wire logic [INDEX_W-1:0] tos_index,
    output logic      [PRIO_W-1:0]  rx_priority
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        vds_pkg::vds_phase_e             ds_phase;
        logic [7:0]                      ds_cmd;
        logic [PRIO_W-1:0]               ds_wr;
        logic [PRIO_W-1:0]               ds_rd;
        logic                            ds_pend;
        vds_pkg::vds_phase_e             vl_phase;
        logic                            vl_pend;
        logic                            vl_read;
        logic                            vl_sel;
        logic [3:0]                      vl_index;
        logic [17:0]                     vl_wval;
        logic [17:0]                     vl_rd;
        logic [VL_ENTRIES-1:0][17:0]     vl_tbl;
        logic [2:0][17:0]                pvid;
        logic [31:0]                     rdata;
        logic                            rvalid;
        logic                            lk_valid;
        logic                            admit;
        logic [2:0]                      egress;
        logic [2:0]                      strip;
    } vds_state_s;

    vds_state_s q;
    vds_state_s d;

    vds_mem_if #(.AW(INDEX_W), .DW(PRIO_W)) mem_bus ();

    logic       m_hit;
    logic [2:0] m_member;
    logic [2:0] m_untag;
    logic       rx_member;
    logic       rx_untag;
    logic       rx_outsider;

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    vds_prio_mem #(.AW(INDEX_W), .DW(PRIO_W)) u_mem (
        .mclk (mclk),
        .bus  (mem_bus)
    );

    vds_vlan_match #(.ENTRIES(VL_ENTRIES)) u_match (
        .table_in (q.vl_tbl),
        .vid      (lookup_vid),
        .hit      (m_hit),
        .member   (m_member),
        .untag    (m_untag)
    );

    assign rx_member   = (lookup_port < 2'd3) ? m_member[lookup_port] : 1'b0;
    assign rx_untag    = (lookup_port < 2'd3) ? m_untag[lookup_port] : 1'b0;
    assign rx_outsider = (lookup_port < 2'd3) ? admit_outsider_ports[lookup_port] : 1'b0;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d              = q;
        d.rvalid       = 1'b0;
        d.lk_valid     = lookup_valid;
        mem_bus.we      = 1'b0;
        mem_bus.addr    = q.ds_cmd[INDEX_W-1:0];
        mem_bus.wdata   = q.ds_wr;
        mem_bus.lk_addr = tos_index;

        // priority table sequencing
        case (q.ds_phase)
            vds_pkg::VDS_ACCESS: begin
                mem_bus.we = ~q.ds_cmd[vds_pkg::CMD_READ_POS];
                d.ds_phase = vds_pkg::VDS_DONE;
            end
            vds_pkg::VDS_DONE: begin
                if (q.ds_cmd[vds_pkg::CMD_READ_POS]) begin
                    d.ds_rd = mem_bus.rq;
                end
                d.ds_pend  = 1'b0;
                d.ds_phase = vds_pkg::VDS_IDLE;
            end
            default: begin
                d.ds_phase = vds_pkg::VDS_IDLE;
            end
        endcase

        // register writes
        if (reg_wr) begin
            if (reg_addr == vds_pkg::REG_PRIO_TABLE_COMMAND) begin
                if (!q.ds_pend) begin
                    d.ds_cmd   = reg_wdata[7:0] & vds_pkg::CMD_WMASK;
                    d.ds_pend  = 1'b1;
                    d.ds_phase = vds_pkg::VDS_ACCESS;
                end
            end else if (reg_addr == vds_pkg::REG_PRIO_TABLE_WRITE_VAL) begin
                d.ds_wr = reg_wdata[PRIO_W-1:0];
            end
        end

        // vlan table sequencing
        case (q.vl_phase)
            vds_pkg::VDS_ACCESS: begin
                if (!q.vl_read) begin
                    if (!q.vl_sel) begin
                        d.vl_tbl[q.vl_index] = q.vl_wval;
                    end else if (q.vl_index < 4'd3) begin
                        d.pvid[q.vl_index[1:0]] = q.vl_wval & vds_pkg::PVID_MASK;
                    end
                end
                d.vl_phase = vds_pkg::VDS_DONE;
            end
            vds_pkg::VDS_DONE: begin
                if (q.vl_read) begin
                    if (!q.vl_sel) begin
                        d.vl_rd = q.vl_tbl[q.vl_index];
                    end else if (q.vl_index < 4'd3) begin
                        d.vl_rd = q.pvid[q.vl_index[1:0]];
                    end else begin
                        d.vl_rd = vds_pkg::VL_ENTRY_RST;
                    end
                end
                d.vl_pend  = 1'b0;
                d.vl_phase = vds_pkg::VDS_IDLE;
            end
            default: begin
                if (vlan_cmd_start) begin
                    d.vl_pend  = 1'b1;
                    d.vl_read  = vlan_cmd_read;
                    d.vl_sel   = default_id_table_select;
                    d.vl_index = vlan_cmd_index;
                    d.vl_wval  = vlan_write_value;
                    d.vl_phase = vds_pkg::VDS_ACCESS;
                end
            end
        endcase

        // per-packet vlan lookup
        d.admit  = lookup_valid & m_hit & (rx_member | rx_outsider);
        d.egress = (lookup_valid & m_hit) ? m_member : 3'h0;
        d.strip  = (lookup_valid & m_hit & rx_untag) ? (m_member & egress_port_kind)
                                                      : 3'h0;

        // register reads, reserved bits read as zero
        if (reg_rd) begin
            d.rvalid = 1'b1;
            if (reg_addr == vds_pkg::REG_VLAN_READ_VALUE) begin
                d.rdata = {14'h0000, q.vl_rd};
            end else if (reg_addr == vds_pkg::REG_VLAN_COMMAND_STATE) begin
                d.rdata = {31'h00000000, q.vl_pend};
            end else if (reg_addr == vds_pkg::REG_PRIO_TABLE_COMMAND) begin
                d.rdata = {24'h000000, q.ds_cmd};
            end else if (reg_addr == vds_pkg::REG_PRIO_TABLE_WRITE_VAL) begin
                d.rdata = {29'h00000000, q.ds_wr};
            end else if (reg_addr == vds_pkg::REG_PRIO_TABLE_READ_VAL) begin
                d.rdata = {29'h00000000, q.ds_rd};
            end else if (reg_addr == vds_pkg::REG_PRIO_TABLE_CMD_STATE) begin
                d.rdata = {31'h00000000, q.ds_pend};
            end else begin
                d.rdata = 32'h00000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            q        <= '0;
            q.ds_cmd <= vds_pkg::CMD_RST;
            q.ds_wr  <= vds_pkg::PRIO_RST;
            q.ds_rd  <= vds_pkg::PRIO_RST;
            q.vl_rd  <= vds_pkg::VL_ENTRY_RST;
            q.vl_tbl <= {VL_ENTRIES{vds_pkg::VL_ENTRY_RST}};
            q.pvid   <= {3{vds_pkg::VL_ENTRY_RST}};
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_q       = q.rdata;
    assign reg_rvalid_q      = q.rvalid;
    assign vlan_read_value_q = q.vl_rd;
    assign lookup_valid_q    = q.lk_valid;
    assign vlan_admit_q      = q.admit;
    assign vlan_egress_q     = q.egress;
    assign vlan_strip_q      = q.strip;
    assign rx_priority       = mem_bus.lk_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic cmd_take;
    assign cmd_take = reg_wr && reg_addr == vds_pkg::REG_PRIO_TABLE_COMMAND && !q.ds_pend;

    prio_pend_start_a: assert property (cmd_take |=> q.ds_pend ##1 q.ds_pend ##1 !q.ds_pend)
        else $error("priority command did not pend for two cycles");
    prio_pend_len_a: assert property ($rose(q.ds_pend) |-> ##[1:2] $fell(q.ds_pend))
        else $error("priority pending flag did not self-clear");
    prio_dir_a: assert property (cmd_take
        |=> mem_bus.we == !$past(reg_wdata[vds_pkg::CMD_READ_POS]))
        else $error("table write strobe disagrees with direction bit");
    prio_read_a: assert property ($fell(q.ds_pend) && q.ds_cmd[7] |-> q.ds_rd == $past(mem_bus.rq))
        else $error("read value not loaded from the table");
    prio_rd_hold_a: assert property (!(q.ds_phase == vds_pkg::VDS_DONE && q.ds_cmd[7]) |=>
        $stable(q.ds_rd))
        else $error("read value changed without a read");
    prio_cmd_resv_a: assert property (reg_rvalid_q && $past(reg_addr) ==
        vds_pkg::REG_PRIO_TABLE_COMMAND |-> reg_rdata_q[31:8] == 24'h0 && !reg_rdata_q[6])
        else $error("reserved command bits read non-zero");
    prio_wr_val_a: assert property (reg_wr && reg_addr == vds_pkg::REG_PRIO_TABLE_WRITE_VAL
        |=> q.ds_wr == $past(reg_wdata[2:0]))
        else $error("write value not stored");
    vlan_pend_a: assert property (vlan_cmd_start && !q.vl_pend |=>
        q.vl_pend [*2] ##1 !q.vl_pend)
        else $error("vlan pending flag wrong length");
    vlan_egress_a: assert property (lookup_valid && !m_hit |=> vlan_egress_q == 3'h0
        && !vlan_admit_q && vlan_strip_q == 3'h0)
        else $error("unmatched vid reached egress");
    vlan_strip_a: assert property (|vlan_strip_q |-> (vlan_strip_q & ~vlan_egress_q) == 3'h0
        && (vlan_strip_q & ~$past(egress_port_kind)) == 3'h0)
        else $error("tag stripped on a non-hybrid or non-member port");
    vlan_admit_a: assert property (lookup_valid && m_hit && rx_member |=> vlan_admit_q)
        else $error("member port not admitted");

    prio_busy_a: assert property (
        reg_wr && reg_addr == vds_pkg::REG_PRIO_TABLE_COMMAND && q.ds_pend
        |=> $stable(q.ds_cmd))
        else $error("command taken while busy");

    vlan_busy_a: assert property (
        vlan_cmd_start && q.vl_pend
        |=> $stable(q.vl_index) && $stable(q.vl_wval))
        else $error("vlan start taken while busy");

    prio_idle_a: assert property (
        q.ds_phase == vds_pkg::VDS_IDLE
        |-> !q.ds_pend)
        else $error("pending flag stuck while idle");

    vlan_rd_load_a: assert property (
        $fell(q.vl_pend) && q.vl_read && !q.vl_sel
        |-> vlan_read_value_q == $past(q.vl_tbl[q.vl_index]))
        else $error("vlan read value not loaded");

    vlan_wr_land_a: assert property (
        q.vl_phase == vds_pkg::VDS_ACCESS && !q.vl_read && !q.vl_sel
        |=> q.vl_tbl[q.vl_index] == q.vl_wval)
        else $error("vlan entry not written");

    vlan_pvid_bits_a: assert property (
        $fell(q.vl_pend) && q.vl_read && q.vl_sel
        |-> vlan_read_value_q[17:15] == 3'h0)
        else $error("default id upper bits non-zero");

    vlan_egress_map_a: assert property (
        lookup_valid && m_hit
        |=> vlan_egress_q == $past(m_member))
        else $error("egress map differs from members");

    vlan_drop_a: assert property (
        lookup_valid && m_hit && !rx_member && !rx_outsider
        |=> !vlan_admit_q)
        else $error("non-member packet admitted");

    vlan_keep_tag_a: assert property (
        lookup_valid && !rx_untag
        |=> vlan_strip_q == 3'h0)
        else $error("tag stripped without untag flag");

    prio_rd_reg_a: assert property (
        reg_rvalid_q && $past(reg_addr) == vds_pkg::REG_PRIO_TABLE_READ_VAL
        |-> reg_rdata_q == {29'h0, $past(q.ds_rd)})
        else $error("read value register wrong");

    prio_pend_reg_a: assert property (
        reg_rvalid_q && $past(reg_addr) == vds_pkg::REG_PRIO_TABLE_CMD_STATE
        |-> reg_rdata_q == {31'h0, $past(q.ds_pend)})
        else $error("priority status register wrong");

    vlan_pend_reg_a: assert property (
        reg_rvalid_q && $past(reg_addr) == vds_pkg::REG_VLAN_COMMAND_STATE
        |-> reg_rdata_q == {31'h0, $past(q.vl_pend)})
        else $error("vlan status register wrong");

    prio_store_a: assert property (
        mem_bus.we
        |=> u_mem.mem_r[$past(mem_bus.addr)] == $past(mem_bus.wdata))
        else $error("table entry not stored");

    // ---------------------------------------------------------------
    // coverage
    // ---------------------------------------------------------------
    prio_read_c: cover property (cmd_take && reg_wdata[7] ##3 reg_rd);
    prio_write_c: cover property (cmd_take && !reg_wdata[7] ##1 mem_bus.we);
    vlan_read_c: cover property (vlan_cmd_start && vlan_cmd_read && !q.vl_pend ##3 !q.vl_pend);
    vlan_admit_c: cover property (lookup_valid && m_hit && !rx_member && rx_outsider);
    vlan_pvid_c: cover property (vlan_cmd_start && default_id_table_select && !q.vl_pend);
endmodule : vds_table_access
`default_nettype wire

// *** test/test_vlan_diffserv_table_access.sv ***
// test_vlan_diffserv_table_access: self-checking bench for vds_table_access.
// assumes the design files and vds_pkg are compiled first; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module test_vlan_diffserv_table_access;
    // ------------------------------
    // signals and instance
    // ------------------------------
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] reg_addr = 16'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata_q;
    logic        reg_rvalid_q;
    logic        vlan_cmd_start = 1'b0;
    logic        vlan_cmd_read = 1'b0;
    logic        default_id_table_select = 1'b0;
    logic [3:0]  vlan_cmd_index = 4'h0;
    logic [17:0] vlan_write_value = 18'h0;
    logic [17:0] vlan_read_value_q;
    logic        lookup_valid = 1'b0;
    logic [11:0] lookup_vid = 12'h0;
    logic [1:0]  lookup_port = 2'h0;
    logic [2:0]  admit_outsider_ports = 3'h0;
    logic [2:0]  egress_port_kind = 3'h0;
    logic        lookup_valid_q;
    logic        vlan_admit_q;
    logic [2:0]  vlan_egress_q;
    logic [2:0]  vlan_strip_q;
    logic [5:0]  tos_index = 6'h0;
    logic [2:0]  rx_priority;
    int          mismatches = 0;
    int          tests_run = 0;
    int          seed = 32'h7526;
    logic [2:0]  pr [64];
    logic [17:0] vt [16];

    always #2 mclk = ~mclk;

    vds_table_access i_vds_table_access (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .vlan_cmd_start(vlan_cmd_start), .vlan_cmd_read(vlan_cmd_read),
        .default_id_table_select(default_id_table_select),
        .vlan_cmd_index(vlan_cmd_index), .vlan_write_value(vlan_write_value),
        .vlan_read_value_q(vlan_read_value_q), .lookup_valid(lookup_valid),
        .lookup_vid(lookup_vid), .lookup_port(lookup_port),
        .admit_outsider_ports(admit_outsider_ports), .egress_port_kind(egress_port_kind),
        .lookup_valid_q(lookup_valid_q), .vlan_admit_q(vlan_admit_q),
        .vlan_egress_q(vlan_egress_q), .vlan_strip_q(vlan_strip_q),
        .tos_index(tos_index), .rx_priority(rx_priority));

    // ------------------------------
    // tasks and expectations
    // ------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("read valid", reg_rvalid_q, 32'h1);
        d = reg_rdata_q;
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // pending must be seen set on the first poll, then clear within a bound
    task automatic poll(input logic [15:0] a);
        logic [31:0] d;
        int          n;
        rd(a, d);
        chk("pending set", d, 32'h1);
        n = 0;
        while (d[0] !== 1'b0 && n < 20) begin
            rd(a, d);
            n++;
        end
        chk("pending clear", d, 32'h0);
    endtask : poll

    task automatic prio_cmd(input logic [31:0] c);
        wr(16'h1811, c);
        poll(16'h1814);
    endtask : prio_cmd

    task automatic vlan_op(input logic r, input logic s, input logic [3:0] i,
                           input logic [17:0] v);
        @(posedge mclk);
        vlan_cmd_start          <= 1'b1;
        vlan_cmd_read           <= r;
        default_id_table_select <= s;
        vlan_cmd_index          <= i;
        vlan_write_value        <= v;
        @(posedge mclk);
        vlan_cmd_start <= 1'b0;
        poll(16'h1810);
    endtask : vlan_op

    // lowest matching index wins, vid zero never matches
    function automatic logic [6:0] lk_exp(input logic [11:0] v, input int p,
                                          input logic [2:0] a, input logic [2:0] k);
        logic [17:0] e;
        logic        hit;
        logic [2:0]  m;
        logic [2:0]  u;
        hit = 1'b0;
        e   = 18'h0;
        for (int j = 15; j >= 0; j--) begin
            if (vt[j][11:0] == v && v != 12'h0) begin
                hit = 1'b1;
                e   = vt[j];
            end
        end
        m = {e[17], e[15], e[13]};
        u = {e[16], e[14], e[12]};
        return {hit & (p < 3) & (m[p] | a[p]), hit ? m : 3'h0,
                (hit & (p < 3) & u[p]) ? (m & k) : 3'h0};
    endfunction : lk_exp

    task automatic final_report;
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial begin
        #80000;
        mismatches++;
        final_report();
    end

    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        logic [31:0] d;
        logic [6:0]  e;
        logic [11:0] v;
        logic [2:0]  a;
        logic [2:0]  k;
        logic        lv;
        int          p;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 16'h180e; i <= 16'h1815; i++) begin
            rd(i[15:0], d);
            chk("reset value", d, 32'h0);
        end
        wr(16'h1812, 32'hffffffff);
        rd(16'h1812, d);
        chk("write value", d, 32'h7);
        wr(16'h1813, 32'hffffffff);
        rd(16'h1813, d);
        chk("read value ro", d, 32'h0);
        prio_cmd(32'hffffff7f);
        rd(16'h1811, d);
        chk("command bits", d, 32'h3f);
        for (int i = 0; i < 64; i++) begin
            pr[i] = $random(seed);
            wr(16'h1812, {29'h0, pr[i]});
            prio_cmd(i);
        end
        for (int i = 63; i >= 0; i--) begin
            prio_cmd(32'h80 | i);
            rd(16'h1813, d);
            chk("table read", d, {29'h0, pr[i]});
            rd(16'h1811, d);
            chk("command read", d, 32'h80 | i);
        end
        for (int i = 0; i < 64; i++) begin
            @(posedge mclk);
            tos_index <= i[5:0];
            @(posedge mclk);
            #1;
            chk("rx priority", rx_priority, pr[i]);
        end
        wr(16'h1811, 32'h85);
        wr(16'h1811, 32'h89);
        rd(16'h1814, d);
        chk("busy pending clear", d, 32'h0);
        rd(16'h1813, d);
        chk("busy command", d, {29'h0, pr[5]});
        rd(16'h1811, d);
        chk("busy command reg", d, 32'h85);
        for (int i = 0; i < 16; i++) begin
            vt[i] = {6'($random(seed)), 12'($random(seed) & 32'hf)};
            vlan_op(1'b0, 1'b0, i[3:0], vt[i]);
        end
        for (int i = 0; i < 16; i++) begin
            vlan_op(1'b1, 1'b0, i[3:0], 18'h0);
            chk("vlan entry", vlan_read_value_q, vt[i]);
            rd(16'h180e, d);
            chk("vlan read reg", d, vt[i]);
        end
        vlan_op(1'b0, 1'b1, 4'h1, 18'h3ffff);
        vlan_op(1'b1, 1'b1, 4'h1, 18'h0);
        chk("default id", vlan_read_value_q, vds_pkg::PVID_MASK);
        vlan_op(1'b0, 1'b1, 4'h3, 18'h3ffff);
        vlan_op(1'b1, 1'b1, 4'h3, 18'h0);
        chk("default id none", vlan_read_value_q, 32'h0);
        repeat (300) begin
            p  = $unsigned($random(seed)) % 4;
            lv = $random(seed);
            v  = 12'($random(seed) & 32'hf);
            a  = $random(seed);
            k  = $random(seed);
            e  = lk_exp(v, p, a, k);
            @(posedge mclk);
            lookup_valid         <= lv;
            lookup_vid           <= v;
            lookup_port          <= p[1:0];
            admit_outsider_ports <= a;
            egress_port_kind     <= k;
            @(posedge mclk);
            #1;
            chk("lookup valid", lookup_valid_q, lv);
            if (lv)
                chk("lookup", {vlan_admit_q, vlan_egress_q, vlan_strip_q}, e);
        end
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(16'h1811, d);
        chk("command after reset", d, 32'h0);
        prio_cmd(32'h85);
        rd(16'h1813, d);
        chk("table kept", d, {29'h0, pr[5]});
        final_report();
    end
endmodule : test_vlan_diffserv_table_access
`default_nettype wire
